/* lsf_pkg.sv */
// Package for the limiter status flag block: register map, flag layout, reset values.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package lsf_pkg;
   localparam int unsigned  LSF_AW            = 8;
   localparam logic [7:0]   LSF_OFS_FLAGS     = 8'h00;
   localparam logic [7:0]   LSF_OFS_MASK      = 8'h04;
   localparam logic [7:0]   LSF_OFS_IRQ_STAT  = 8'h08;
   localparam logic [7:0]   LSF_OFS_IRQ_EN    = 8'h0c;
   localparam logic [7:0]   LSF_OFS_IRQ_CLR   = 8'h10;
   localparam logic [7:0]   LSF_OFS_LIM_CTRL  = 8'h14;
   localparam logic [31:0]  LSF_FLAGS_RST     = 32'h0000_0000;
   localparam logic [31:0]  LSF_MASK_RST      = 32'h0000_0000;
   localparam logic [31:0]  LSF_USED_BITS     = 32'h7f7f_ffff;
   localparam logic [31:0]  LSF_ZERO          = 32'h0000_0000;
   localparam int unsigned  LSF_NLOOP         = 4;
   localparam int unsigned  LSF_VOLT_LSB      = 16;
   localparam int unsigned  LSF_PLL_BIT       = 19;
   localparam int unsigned  LSF_REFSW_LSB     = 20;
   localparam int unsigned  LSF_PWM_LSB       = 24;
   localparam int unsigned  LSF_ADC_LSB       = 26;
   localparam int unsigned  LSF_IDX_LSB       = 28;
   // Interrupt status/enable/clear bit positions
   localparam int unsigned  LSF_IRQ_STATUS    = 0;
   localparam int unsigned  LSF_IRQ_WDOG      = 1;
   localparam int unsigned  LSF_IRQ_W         = 2;
   localparam logic [15:0]  LSF_LIM_DFLT      = 16'h7fff;
   typedef enum logic [1:0] {LSF_ST_IDLE, LSF_ST_ACCESS} lsf_apb_st_t;
endpackage

/* lsf_loop_if.sv */
// Carries one PI loop's limiter events toward the flag collector.
// Driven by the limiter modules, read by the top.
`timescale 1ns/100ps
interface lsf_loop_if;
   logic target_clipped;
   logic rate_clipped;
   logic integrator_clipped;
   logic output_clipped;
   modport src
   (
      output target_clipped,
      output rate_clipped,
      output integrator_clipped,
      output output_clipped
   );
   modport dst
   (
      input target_clipped,
      input rate_clipped,
      input integrator_clipped,
      input output_clipped
   );
endinterface

/* lsf_loop_limiter.sv */
// One PI loop's limiter stage: target clamp, rate clamp, integrator and output clamp.
// Operands arrive from same-clock logic; an unsigned limit, applied as a symmetric bound, comes from a register.
`timescale 1ns/100ps
module lsf_loop_limiter
   import lsf_pkg::*;
(
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // Limit settings
   input  wire logic [15:0]        limit,
   input  wire logic [15:0]        rate_limit,
   input  wire logic               rate_en,
   // Loop operands
   input  wire logic signed [15:0] target_raw,
   input  wire logic signed [15:0] target_offset,
   input  wire logic signed [31:0] errsum_raw,
   input  wire logic signed [31:0] output_raw,
   // Results
   output logic signed [15:0]      target_lim,
   output logic signed [31:0]      errsum_lim,
   output logic signed [31:0]      output_lim,
   lsf_loop_if.src                 ev
);
   logic signed [16:0] sum;
   logic signed [16:0] lim17;
   logic signed [16:0] tgt_clip;
   logic signed [16:0] step;
   logic signed [16:0] rl17;
   logic signed [31:0] lim32;
   logic signed [15:0] prev_q;
   logic signed [15:0] prev_d;

   always_comb
   begin
      lim17 = signed'({1'b0, limit});
      rl17  = signed'({1'b0, rate_limit});
      lim32 = signed'({16'h0000, limit});
      // Offset is added before the clamp, so offsets cannot push past the limit
      sum   = 17'(target_raw) + 17'(target_offset); // RULE12
      tgt_clip = sum;
      ev.target_clipped = 1'b0;
      if (sum > lim17)
      begin
         tgt_clip = lim17; // RULE12
         ev.target_clipped = 1'b1; // RULE8
      end
      else if (sum < -lim17)
      begin
         tgt_clip = -lim17;
         ev.target_clipped = 1'b1;
      end
      step = tgt_clip - 17'(prev_q);
      ev.rate_clipped = 1'b0;
      prev_d = tgt_clip[15:0];
      if (rate_en && step > rl17)
      begin
         prev_d = 16'(17'(prev_q) + rl17); // RULE14
         ev.rate_clipped = 1'b1; // RULE14
      end
      else if (rate_en && step < -rl17)
      begin
         prev_d = 16'(17'(prev_q) - rl17);
         ev.rate_clipped = 1'b1;
      end
      target_lim = prev_d;
      // Integrator shares the output bounds to avoid windup past the output range
      errsum_lim = errsum_raw; // RULE13
      ev.integrator_clipped = 1'b0;
      if (errsum_raw > lim32)
      begin
         errsum_lim = lim32;
         ev.integrator_clipped = 1'b1;
      end
      else if (errsum_raw < -lim32)
      begin
         errsum_lim = -lim32;
         ev.integrator_clipped = 1'b1;
      end
      output_lim = output_raw; // RULE12
      ev.output_clipped = 1'b0;
      if (output_raw > lim32)
      begin
         output_lim = lim32;
         ev.output_clipped = 1'b1;
      end
      else if (output_raw < -lim32)
      begin
         output_lim = -lim32;
         ev.output_clipped = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev_q <= '0;
      else
         prev_q <= prev_d;
   end
endmodule

/* lsf_status_flags.sv */
// Limiter status flag collector with APB register access and a masked status pin.
// Event inputs marked as pins pass a two-flop synchroniser; the rest are same-clock logic.
// Functional notes
// RULE1 - Each of the position, velocity, d-current and q-current loops owns four flags in bits 0-15.
// RULE2 - Bits 16 to 18 report clipping of the d, q and resulting voltage in the circular limiter.
// RULE3 - Bit 19 reports that the phase-locked loop is not locked.
// RULE4 - Right, home and left reference switches appear in bits 20 to 22.
// RULE5 - Bits 24 and 25 report PWM duty saturation at minimum and maximum.
// RULE6 - Bits 26 and 27 report phase-current ADC and analog encoder ADC clipping.
// RULE7 - Bits 28 to 30 report index events of encoder 1, encoder 2 and the analog encoder.
// RULE8 - An active limiter drives its flag bit high.
// RULE9 - A mask register selects which flags may drive the status pin.
// RULE10 - Software may write the flag register as a whole word.
// RULE11 - No single-bit clear exists; only a full-word write changes flags.
// RULE12 - Each controller clamps its offset-added target and its output.
// RULE13 - Each integrator sum is clamped to the output bounds.
// RULE14 - With rate limiting on, target slew is restricted and the rate flag rises.
// RULE15 - A watchdog fault flag is kept for faults on the clock input.
// RULE16 - The status pin is high while flags AND mask is nonzero.
// RULE17 - Bits 23 and 31 read as zero and ignore writes.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
module lsf_status_flags
   import lsf_pkg::*;
(
   // APB
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [LSF_AW-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Loop operands, index 0 position, 1 velocity, 2 d-current, 3 q-current
   input  wire logic signed [15:0]   loop_target  [LSF_NLOOP],
   input  wire logic signed [15:0]   loop_offset  [LSF_NLOOP],
   input  wire logic signed [31:0]   loop_errsum  [LSF_NLOOP],
   input  wire logic signed [31:0]   loop_output  [LSF_NLOOP],
   output logic signed [15:0]        loop_target_lim [LSF_NLOOP],
   output logic signed [31:0]        loop_errsum_lim [LSF_NLOOP],
   output logic signed [31:0]        loop_output_lim [LSF_NLOOP],
   // Same-clock event sources
   input  wire logic [2:0]           volt_clipped,
   input  wire logic                 pll_unlocked,
   input  wire logic                 pwm_min_sat,
   input  wire logic                 pwm_max_sat,
   input  wire logic                 adc_current_clipped,
   input  wire logic                 adc_encoder_clipped,
   input  wire logic                 clock_watchdog_fault,
   // Pin event sources
   input  wire logic                 right_reference_switch,
   input  wire logic                 home_reference_switch,
   input  wire logic                 left_reference_switch,
   input  wire logic                 encoder1_index,
   input  wire logic                 encoder2_index,
   input  wire logic                 aencoder_index,
   // Status and interrupt
   output logic                      status_out,
   output logic                      irq
);
   logic [31:0]  flags_q;
   logic [31:0]  flags_d;
   logic [31:0]  mask_q;
   logic [31:0]  mask_d;
   logic [31:0]  lim_ctrl_q;
   logic [31:0]  lim_ctrl_d;
   logic [LSF_IRQ_W-1:0] ist_q;
   logic [LSF_IRQ_W-1:0] ist_d;
   logic [LSF_IRQ_W-1:0] ien_q;
   logic [LSF_IRQ_W-1:0] ien_d;
   logic [5:0]   pin_s1_q;
   logic [5:0]   pin_s2_q;
   logic [31:0]  events;
   logic [31:0]  prdata_d;
   logic         pslverr_d;
   logic         pready_d;
   logic         status_d;
   logic         irq_d;
   logic         status_rise;
   logic         wr_en;
   logic         hit;
   lsf_apb_st_t  st_q;
   lsf_apb_st_t  st_d;
   logic [15:0]  loop_flags;
   logic signed [15:0] loop_target_lim_d [LSF_NLOOP];
   logic signed [31:0] loop_errsum_lim_d [LSF_NLOOP];
   logic signed [31:0] loop_output_lim_d [LSF_NLOOP];

   lsf_loop_if loop_ev [LSF_NLOOP] ();

   genvar g;
   generate
      for (g = 0; g < LSF_NLOOP; g++)
      begin : g_loop
         lsf_loop_limiter u_lim
         (
            .pclk          (pclk),
            .presetn       (presetn),
            .limit         (lim_ctrl_q[15:0]),
            .rate_limit    ({1'b0, lim_ctrl_q[30:16]}),
            .rate_en       (lim_ctrl_q[31]),
            .target_raw    (loop_target[g]),
            .target_offset (loop_offset[g]),
            .errsum_raw    (loop_errsum[g]),
            .output_raw    (loop_output[g]),
            .target_lim    (loop_target_lim_d[g]),
            .errsum_lim    (loop_errsum_lim_d[g]),
            .output_lim    (loop_output_lim_d[g]),
            .ev            (loop_ev[g])
         );
         assign loop_flags[4*g]   = loop_ev[g].target_clipped; // RULE1
         assign loop_flags[4*g+1] = loop_ev[g].rate_clipped;
         assign loop_flags[4*g+2] = loop_ev[g].integrator_clipped;
         assign loop_flags[4*g+3] = loop_ev[g].output_clipped;
      end
   endgenerate

   // Pins are asynchronous to pclk; only the second stage is looked at
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end
      else
      begin
         pin_s1_q <= {aencoder_index, encoder2_index, encoder1_index,
                      left_reference_switch, home_reference_switch,
                      right_reference_switch};
         pin_s2_q <= pin_s1_q;
      end
   end

   always_comb
   begin
      events = LSF_ZERO;
      events[15:0] = loop_flags; // RULE1
      events[LSF_VOLT_LSB +: 3] = volt_clipped; // RULE2
      events[LSF_PLL_BIT] = pll_unlocked; // RULE3
      events[LSF_REFSW_LSB +: 3] = pin_s2_q[2:0]; // RULE4
      events[LSF_PWM_LSB] = pwm_min_sat; // RULE5
      events[LSF_PWM_LSB + 1] = pwm_max_sat;
      events[LSF_ADC_LSB] = adc_current_clipped; // RULE6
      events[LSF_ADC_LSB + 1] = adc_encoder_clipped;
      events[LSF_IDX_LSB +: 3] = pin_s2_q[5:3]; // RULE7
      events = events & LSF_USED_BITS; // RULE17
   end

   assign wr_en = psel && penable && pwrite && st_q == LSF_ST_ACCESS;
   assign hit   = paddr == LSF_OFS_FLAGS || paddr == LSF_OFS_MASK
                  || paddr == LSF_OFS_IRQ_STAT || paddr == LSF_OFS_IRQ_EN
                  || paddr == LSF_OFS_IRQ_CLR || paddr == LSF_OFS_LIM_CTRL;

   // Zero-wait slave: one setup cycle, then pready in the access cycle
   always_comb
   begin
      st_d     = st_q;
      pready_d = 1'b0;
      unique case (st_q)
         LSF_ST_IDLE:
         begin
            if (psel && !penable)
            begin
               st_d     = LSF_ST_ACCESS;
               pready_d = 1'b1;
            end
         end
         LSF_ST_ACCESS:
         begin
            st_d = LSF_ST_IDLE;
            if (psel && !penable)
            begin
               st_d     = LSF_ST_ACCESS;
               pready_d = 1'b1;
            end
         end
      endcase
   end

   always_comb
   begin
      flags_d    = flags_q;
      mask_d     = mask_q;
      lim_ctrl_d = lim_ctrl_q;
      ien_d      = ien_q;
      ist_d      = ist_q;
      // Only a whole-word write changes stored flags; events still win below
      if (wr_en && paddr == LSF_OFS_FLAGS)
         flags_d = pwdata & LSF_USED_BITS; // RULE10 RULE11 RULE17
      flags_d = flags_d | events; // RULE8
      if (wr_en && paddr == LSF_OFS_MASK)
         mask_d = pwdata & LSF_USED_BITS; // RULE9
      if (wr_en && paddr == LSF_OFS_LIM_CTRL)
         lim_ctrl_d = pwdata;
      if (wr_en && paddr == LSF_OFS_IRQ_EN)
         ien_d = pwdata[LSF_IRQ_W-1:0];
      if (wr_en && paddr == LSF_OFS_IRQ_CLR)
         ist_d = ist_q & ~pwdata[LSF_IRQ_W-1:0];
      // Set beats a same-cycle clear
      if (status_rise)
         ist_d[LSF_IRQ_STATUS] = 1'b1;
      if (clock_watchdog_fault)
         ist_d[LSF_IRQ_WDOG] = 1'b1; // RULE15
      status_d = |(flags_d & mask_d); // RULE16
      irq_d    = |(ist_d & ien_d);
   end

   // Read data and refusal are decided at setup so they stand beside pready
   always_comb
   begin
      prdata_d  = LSF_ZERO;
      pslverr_d = 1'b0;
      if (psel && !penable)
         pslverr_d = !hit;
      if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            LSF_OFS_FLAGS:    prdata_d = flags_q;
            LSF_OFS_MASK:     prdata_d = mask_q;
            LSF_OFS_IRQ_STAT: prdata_d = {30'h0, ist_q};
            LSF_OFS_IRQ_EN:   prdata_d = {30'h0, ien_q};
            LSF_OFS_LIM_CTRL: prdata_d = lim_ctrl_q;
            default:          prdata_d = LSF_ZERO;
         endcase
      end
   end

   assign status_rise = status_d && !status_out;

   // Bus response state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q       <= LSF_ST_IDLE;
         prdata     <= '0;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end
      else
      begin
         st_q       <= st_d;
         prdata     <= prdata_d;
         pready     <= pready_d;
         pslverr    <= pslverr_d;
      end
   end

   // Software-visible registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags_q    <= LSF_FLAGS_RST;
         mask_q     <= LSF_MASK_RST;
         lim_ctrl_q <= {16'h0000, LSF_LIM_DFLT};
         ist_q      <= '0;
         ien_q      <= '0;
      end
      else
      begin
         flags_q    <= flags_d;
         mask_q     <= mask_d;
         lim_ctrl_q <= lim_ctrl_d;
         ist_q      <= ist_d;
         ien_q      <= ien_d;
      end
   end

   // Status pin and interrupt line
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_out <= 1'b0;
         irq        <= 1'b0;
      end
      else
      begin
         status_out <= status_d; // RULE9
         irq        <= irq_d;
      end
   end

   // Limiter results leave through flops like every other output; costs one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < LSF_NLOOP; i++)
         begin
            loop_target_lim[i] <= '0;
            loop_errsum_lim[i] <= '0;
            loop_output_lim[i] <= '0;
         end
      end
      else
      begin
         for (int i = 0; i < LSF_NLOOP; i++)
         begin
            loop_target_lim[i] <= loop_target_lim_d[i];
            loop_errsum_lim[i] <= loop_errsum_lim_d[i];
            loop_output_lim[i] <= loop_output_lim_d[i];
         end
      end
   end
endmodule

/* lsf_status_flags_monitor.sv */
// Checker for the limiter status flag block, bound to its top module.
// Sees APB and a few event ports; flag contents are judged through reads.
`timescale 1ns/100ps
module lsf_status_flags_monitor
   import lsf_pkg::*;
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [LSF_AW-1:0] paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Events
   input wire logic [2:0]        volt_clipped,
   input wire logic              pll_unlocked,
   input wire logic              pwm_max_sat
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_flags;
   // Read data is launched one edge before pready is sampled
   assign rd_flags = pready && !pwrite && paddr == LSF_OFS_FLAGS;
   a_pready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_pready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_unmapped_err: assert property (pready && paddr > LSF_OFS_LIM_CTRL |->
      pslverr && (pwrite || prdata == LSF_ZERO)) else $error("unmapped access not refused");
   a_mapped_ok: assert property (pready && paddr <= LSF_OFS_LIM_CTRL |-> !pslverr)
      else $error("mapped access refused");
   a_reserved_zero: assert property (rd_flags |-> !prdata[23] && !prdata[31])
      else $error("reserved flag bit set");
   a_volt_flags: assert property (rd_flags |->
      ($past(volt_clipped, 2) & ~prdata[18:16]) == 3'h0) else $error("voltage flag lost");
   a_pll_flag: assert property (rd_flags && $past(pll_unlocked, 2) |-> prdata[19])
      else $error("unlock flag lost");
   a_pwm_max_flag: assert property (rd_flags && $past(pwm_max_sat, 2) |-> prdata[25])
      else $error("duty max flag lost");
   c_flag_read: cover property (rd_flags && prdata != LSF_ZERO);
   c_refused: cover property (pslverr);
   c_unlock_read: cover property (rd_flags && prdata[19]);
endmodule
bind lsf_status_flags lsf_status_flags_monitor lsf_status_flags_monitor_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .volt_clipped(volt_clipped), .pll_unlocked(pll_unlocked), .pwm_max_sat(pwm_max_sat));

/* lsf_host_model.sv */
// Host side: treats the status line as an interrupt and counts its rising edges.
// Assumes a registered status level in the pclk domain.
`timescale 1ns/100ps
module lsf_host_model
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Line from the device
   input  wire logic status_out,
   // Observation
   output logic [7:0] rises
);
   logic prev_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_q <= 1'b0;
         rises  <= 8'h00;
      end
      else
      begin
         prev_q <= status_out;
         if (status_out && !prev_q)
            rises <= rises + 8'h01;
      end
   end
endmodule

/* test_lsf_status_flags.sv */
// Self-checking bench for the limiter status flag block.
// Drives APB and events on rising edges; a host model counts status rises.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t %h %h", $time, g, e); end end
module test_lsf_status_flags;
   import lsf_pkg::*;
   logic               pclk = 1'b0;
   logic               presetn = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [LSF_AW-1:0]  paddr = '0;
   logic [31:0]        pwdata = '0;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic signed [15:0] tgt [LSF_NLOOP] = '{default: '0};
   logic signed [15:0] ofs [LSF_NLOOP] = '{default: '0};
   logic signed [31:0] esum [LSF_NLOOP] = '{default: '0};
   logic signed [31:0] outv [LSF_NLOOP] = '{default: '0};
   logic signed [15:0] tgt_l [LSF_NLOOP];
   logic signed [31:0] esum_l [LSF_NLOOP];
   logic signed [31:0] out_l [LSF_NLOOP];
   logic [13:0]        ev = '0;
   logic               wdf = 1'b0;
   logic               status_out;
   logic               irq;
   logic [7:0]         srise;
   int                 bad_count = 0;
   int                 num_checks = 0;
   // Flag bit expected for each event line, in the order of ev
   int                 fbit [14] = '{16, 17, 18, 19, 24, 25, 26, 27, 20, 21, 22, 28, 29, 30};
   always #5 pclk = ~pclk;
   lsf_status_flags lsf_status_flags_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .loop_target(tgt), .loop_offset(ofs), .loop_errsum(esum), .loop_output(outv),
      .loop_target_lim(tgt_l), .loop_errsum_lim(esum_l), .loop_output_lim(out_l),
      .volt_clipped(ev[2:0]), .pll_unlocked(ev[3]), .pwm_min_sat(ev[4]),
      .pwm_max_sat(ev[5]), .adc_current_clipped(ev[6]), .adc_encoder_clipped(ev[7]),
      .clock_watchdog_fault(wdf), .right_reference_switch(ev[8]),
      .home_reference_switch(ev[9]), .left_reference_switch(ev[10]),
      .encoder1_index(ev[11]), .encoder2_index(ev[12]), .aencoder_index(ev[13]),
      .status_out(status_out), .irq(irq));
   lsf_host_model lsf_host_model_i (
      .pclk(pclk), .presetn(presetn), .status_out(status_out), .rises(srise));
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] x, input logic xe);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      `CHK(pslverr, xe)
      if (!w)
         `CHK(prdata, x)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d, '0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      acc(1'b0, a, '0, x, 1'b0);
   endtask
   task automatic tally_and_finish;
      if (bad_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #100us;
      bad_count++;
      tally_and_finish;
   end
   initial
   begin
      tick(16);
      presetn <= 1'b1;
      rd(LSF_OFS_FLAGS, LSF_FLAGS_RST);
      rd(LSF_OFS_MASK, LSF_MASK_RST);
      rd(LSF_OFS_LIM_CTRL, 32'h0000_7fff);
      rd(LSF_OFS_IRQ_EN, 32'h0);
      acc(1'b0, 8'h40, '0, '0, 1'b1);
      acc(1'b1, 8'h40, 32'hffff_ffff, '0, 1'b1);
      wr(LSF_OFS_FLAGS, 32'hffff_ffff);
      rd(LSF_OFS_FLAGS, LSF_USED_BITS);
      wr(LSF_OFS_FLAGS, 32'h0000_0100);
      rd(LSF_OFS_FLAGS, 32'h0000_0100);
      wr(LSF_OFS_FLAGS, '0);
      // Event held across the read, so the flag shows while still active
      for (int k = 0; k < 14; k++)
      begin
         ev <= 14'(1) << k;
         tick(3);
         rd(LSF_OFS_FLAGS, 32'(1) << fbit[k]);
         ev <= '0;
         wr(LSF_OFS_FLAGS, '0);
      end
      wr(LSF_OFS_LIM_CTRL, 32'h0000_1000);
      for (int i = 0; i < LSF_NLOOP; i++)
      begin
         tgt[i] <= 16'sh0800;
         ofs[i] <= 16'sh0900;
         esum[i] <= 32'sh2000;
         outv[i] <= 32'shffff_e000;
         tick(2);
         `CHK(tgt_l[i], 16'sh1000)
         `CHK(esum_l[i], 32'sh1000)
         `CHK(out_l[i], 32'shffff_f000)
         tgt[i] <= '0;
         ofs[i] <= '0;
         esum[i] <= '0;
         outv[i] <= '0;
         rd(LSF_OFS_FLAGS, 32'hd << (4 * i));
         wr(LSF_OFS_FLAGS, '0);
      end
      wr(LSF_OFS_LIM_CTRL, 32'h8001_1000);
      tgt[1] <= 16'sh0400;
      tick(4);
      `CHK(tgt_l[1] < 16'sh0400, 1'b1)
      rd(LSF_OFS_FLAGS, 32'h0000_0020);
      wr(LSF_OFS_LIM_CTRL, 32'h0000_1000);
      tgt[1] <= '0;
      wr(LSF_OFS_FLAGS, '0);
      wr(LSF_OFS_IRQ_EN, 32'h3);
      wr(LSF_OFS_MASK, 32'h0200_0000);
      ev <= 14'h10;
      tick(4);
      `CHK(status_out, 1'b0)
      ev <= 14'h20;
      tick(4);
      `CHK(status_out, 1'b1)
      `CHK(srise, 8'h01)
      `CHK(irq, 1'b1)
      ev <= '0;
      rd(LSF_OFS_IRQ_STAT, 32'h1);
      wr(LSF_OFS_IRQ_CLR, 32'h1);
      tick(2);
      `CHK(irq, 1'b0)
      wr(LSF_OFS_MASK, '0);
      tick(2);
      `CHK(status_out, 1'b0)
      wdf <= 1'b1;
      tick(1);
      wdf <= 1'b0;
      tick(4);
      rd(LSF_OFS_IRQ_STAT, 32'h2);
      `CHK(irq, 1'b1)
      wr(LSF_OFS_IRQ_EN, 32'h1);
      tick(2);
      `CHK(irq, 1'b0)
      wr(LSF_OFS_IRQ_CLR, 32'h2);
      rd(LSF_OFS_IRQ_STAT, 32'h0);
      tally_and_finish;
   end
endmodule
